// ---- sim/nps_flash_model.sv ----
// Behavioural flash device on the sequencer's pins: commands, busy timer, status, ID.
// Assumes byte-wide strobes from one host; io shows the inverse of the last byte when idle.
module nps_flash_model #(
  parameter int         BUSY_NS   = 2000,
  parameter logic [7:0] MAKER_ID  = 8'h5A,  // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3C   // Arbitrary value
) (
  // Pins from the host
  input  wire nps_pkg::nps_pins_type pins,
  // Next array operation reports a failure
  input  wire logic                  fail_next,
  // Pins to the host
  output logic [7:0]                 io_in,
  output logic                       rb_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cmd = 8'hFF;
  logic [7:0] last = 8'h00;
  logic [7:0] stat = 8'hE0;
  logic [7:0] id_q [$];
  initial rb_ready = 1'b1;
  initial io_in = 8'hA5;

  // Cache ready returns one period before the array finishes
  task automatic run_busy(input logic cache, input logic fail);
    rb_ready = 1'b0;
    stat[6:5] = 2'b00;
    #(BUSY_NS);  // Runs on whatever ce_n does
    stat[1] = stat[0];
    stat[6] = 1'b1;
    rb_ready = 1'b1;
    if (cache) #(BUSY_NS);
    stat[0] = fail;
    stat[5] = 1'b1;
  endtask : run_busy

  // Bytes latch at the strobe rise; only status is heard while busy
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle && (rb_ready || pins.io_out == nps_pkg::CMD_STATUS)) begin
      cmd = pins.io_out;
      if (cmd inside {nps_pkg::CMD_CONFIRM, nps_pkg::CMD_CACHE, nps_pkg::CMD_ERASE_CONF}) begin
        fork
          run_busy(cmd == nps_pkg::CMD_CACHE, fail_next);
        join_none
      end
    end else if (!pins.ce_n && pins.ale && cmd == nps_pkg::CMD_ID) begin
      if (pins.io_out == nps_pkg::ID_ADDR_ONFI)
        id_q = '{8'h4F, 8'h4E, 8'h46, 8'h49};
      else
        id_q = '{MAKER_ID, DEVICE_ID, 8'h90, 8'h15, 8'h56};
    end
  end

  // Read strobe fall presents a byte; release shows its inverse
  always @(negedge pins.re_n) begin
    if (cmd == nps_pkg::CMD_STATUS)
      last = {pins.wp_n, stat[6:0]};
    else if (id_q.size() > 0)
      last = id_q.pop_front();
    else
      last = ~last;
    io_in = last;
  end
  always @(posedge pins.re_n or posedge pins.ce_n) io_in = ~last;
endmodule : nps_flash_model

// ---- sim/testbench.sv ----
// Self-checking bench: AHB-Lite master tasks, random loads and corner cases.
// Assumes the flash model on the pins and a short page of 16 units.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         UNITS = 16;
  localparam logic [7:0] MAKER = 8'h5A;  // Arbitrary value
  localparam logic [7:0] DEV   = 8'h3C;  // Arbitrary value
  logic                  hclk = 1'b0;
  logic                  hresetn = 1'b0;
  logic                  hsel = 1'b0;
  logic [31:0]           haddr = 32'h0;
  logic [1:0]            htrans = 2'h0;
  logic                  hwrite = 1'b0;
  logic [31:0]           hwdata = 32'h0;
  logic                  fail_next = 1'b0;
  logic                  hreadyout, hresp, rb_ready;
  logic [31:0]           hrdata, rd;
  logic [7:0]            io_in;
  logic [23:0]           blk;
  nps_pkg::nps_pins_type pins;
  int                    bad_count = 0;
  int                    n_compared = 0;
  int                    cycles = 0;

  nps_host #(.PAGE_UNITS(UNITS)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pins(pins),
    .io_in(io_in), .rb_ready(rb_ready));
  nps_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEV)) i_flash (.pins(pins),
    .fail_next(fail_next), .io_in(io_in), .rb_ready(rb_ready));

  // Clock and a ceiling far above the expected run length
  always #20 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Request held until hready is seen high; read data taken at the closing edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check("response", hresp, 1'b0);
  endtask : ahb

  task automatic st;
    ahb(1'b0, nps_pkg::OFS_STAT, 32'h0);
  endtask : st

  // Orders are refused while bytes still strobe, so wait for idle or load phase on both sides
  task automatic ctl(input nps_pkg::nps_op_type op);
    settle();
    ahb(1'b1, nps_pkg::OFS_CTRL, {29'h0, op});
    settle();
  endtask : ctl

  // Polling keeps the bus busy, so the wait relies on the global ceiling
  task automatic settle;
    do
      st();
    while (rd[0] !== 1'b0);
  endtask : settle

  // Page load with a column jump in the middle, then the given finishing op
  task automatic prog(input logic [23:0] row, input nps_pkg::nps_op_type fin);
    ahb(1'b1, nps_pkg::OFS_COL, $urandom_range(3));
    ahb(1'b1, nps_pkg::OFS_ROW, {8'h0, row});
    ctl(nps_pkg::OP_PROG);
    repeat ($urandom_range(8, 1)) ahb(1'b1, nps_pkg::OFS_DATA, $urandom_range(255));
    settle();
    check("load phase", rd[1], 1'b1);
    check("ready before confirm", rb_ready, 1'b1);
    ahb(1'b1, nps_pkg::OFS_COL, $urandom_range(7));
    ctl(nps_pkg::OP_JUMP);
    ahb(1'b1, nps_pkg::OFS_DATA, $urandom_range(255));
    ctl(fin);
    settle();
    check("no error", rd[5:2], 4'h0);
  endtask : prog

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  initial begin
    void'($urandom(32'h7776));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'hFC, 32'h0);
    check("unmapped", rd, 32'h0);
    // Standard identification, then the ONFI signature
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, nps_pkg::OFS_COL, k ? 32'h20 : 32'h0);
      ahb(1'b0, nps_pkg::OFS_COL, 32'h0);
      check("column readback", rd, k ? 32'h20 : 32'h0);
      ctl(nps_pkg::OP_ID);
      settle();
      check("id count", rd[21:19], k ? 3'h4 : 3'h5);
      ahb(1'b0, nps_pkg::OFS_ID_LO, 32'h0);
      check("id low", rd, k ? 32'h49464E4F : {8'h15, 8'h90, DEV, MAKER});
      ahb(1'b0, nps_pkg::OFS_ID_HI, 32'h0);
      if (k == 0) check("id high", rd, 32'h56);
    end
    // Pass then fail on rising pages, then a lower page is refused
    blk = 24'($urandom_range(1000)) << 6;
    for (int f = 0; f < 2; f++) begin
      fail_next <= f[0];
      prog(blk + 24'(f), nps_pkg::OP_CONFIRM);
      check("chip fail", rd[15], f[0]);
      check("ready bits", rd[18:17], 2'b11);
    end
    ahb(1'b1, nps_pkg::OFS_ROW, {8'h0, blk});
    ctl(nps_pkg::OP_PROG);
    st();
    check("order error", rd[2 + nps_pkg::ERR_ORDER], 1'b1);
    // Fifth program of one page refused until the block is erased
    fail_next <= 1'b0;
    blk = blk + 24'h40;
    repeat (4) prog(blk, nps_pkg::OP_CONFIRM);
    ctl(nps_pkg::OP_PROG);
    st();
    check("partial error", rd[2 + nps_pkg::ERR_PARTIAL], 1'b1);
    fail_next <= 1'b1;
    ctl(nps_pkg::OP_ERASE);
    settle();
    check("erase result", rd[15], 1'b1);
    fail_next <= 1'b0;
    prog(blk, nps_pkg::OP_CONFIRM);
    // Loading past the page end is refused
    ahb(1'b1, nps_pkg::OFS_ROW, {8'h0, blk + 24'h1});
    ctl(nps_pkg::OP_PROG);
    repeat (UNITS + 1) ahb(1'b1, nps_pkg::OFS_DATA, $urandom_range(255));
    st();
    check("full error", rd[2 + nps_pkg::ERR_FULL], 1'b1);
    ctl(nps_pkg::OP_CONFIRM);
    settle();
    // Cache pages: the failed first page shows as previous result on the second
    blk = blk + 24'h40;
    fail_next <= 1'b1;
    prog(blk, nps_pkg::OP_CACHE);
    check("cache ready", rd[18], 1'b1);
    fail_next <= 1'b0;
    prog(blk + 24'h1, nps_pkg::OP_CACHE);
    check("cache fail", rd[16], 1'b1);
    prog(blk + 24'h2, nps_pkg::OP_CONFIRM);
    check("last page", rd[17:15], 3'b100);
    ctl(nps_pkg::OP_STATUS);
    settle();
    check("status byte", rd[14:7], 8'hE0);
    ctl(nps_pkg::OP_DATA);
    st();
    check("refused op", rd[2 + nps_pkg::ERR_REFUSED], 1'b1);
    tally_and_finish();
  end
endmodule : testbench

// ---- src/nps_host.sv ----
// AHB-Lite controlled host sequencer driving a NAND device's byte-wide pins.
// Assumes one AHB-Lite master, word transfers, and R/B high meaning ready.
module nps_host #(
  parameter int PAGE_UNITS = 2112
) (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  // NAND pins
  output nps_pkg::nps_pins_type    pins,
  input  wire logic [7:0]          io_in,
  input  wire logic                rb_ready
);
  typedef enum {S_IDLE, S_ISSUE, S_LOAD, S_WB, S_RDY, S_WHR, S_READ} nps_state_type;

  nps_state_type         state, next_state;
  nps_pkg::nps_op_type   op, next_op;
  nps_pkg::nps_pins_type next_pins;
  nps_pkg::nps_step_type st;
  nps_pkg::nps_stat_type stat_rd;
  nps_pkg::nps_op_type   opc;
  logic [2:0]  step, next_step, rcnt, next_rcnt, rlen, next_rlen, pcnt, next_pcnt;
  logic [4:0]  tcnt, next_tcnt;
  logic [15:0] col, next_col;
  logic [23:0] row, next_row, last_row, next_last_row;
  logic [11:0] col_ptr, next_col_ptr;
  logic [7:0]  dbyte, next_dbyte, nstat, next_nstat;
  logic [7:0]  idb [nps_pkg::ID_MAX];
  logic [7:0]  next_idb [nps_pkg::ID_MAX];
  logic [3:0]  err, next_err;
  logic        last_valid, next_last_valid;
  logic        ap_valid, next_ap_valid, ap_write, next_ap_write;
  logic [7:0]  ap_ofs, next_ap_ofs;
  logic        next_hreadyout;
  logic [31:0] next_hrdata;
  logic        stall, same_blk, same_pg;
  logic [7:0]  io_s;
  logic        rb_s;

  // Pins pass four flops before use
  nps_sync #(.W(9)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({rb_ready, io_in}),
    .q       ({rb_s, io_s})
  );

  // Byte to put on the pins for each step of an operation
  function automatic nps_pkg::nps_step_type seq_byte(input nps_pkg::nps_op_type o,
      input logic [2:0] s, input logic [15:0] c, input logic [23:0] r, input logic [7:0] d);
    nps_pkg::nps_step_type t;
    t = '{kind: nps_pkg::K_ADDR, last: 1'b0, data: 8'h00};
    unique case (o)
      nps_pkg::OP_PROG, nps_pkg::OP_JUMP: begin
        t.data = (s == 3'h1) ? c[7:0] : (s == 3'h2) ? c[15:8] : (s == 3'h3) ? r[7:0] :
                 (s == 3'h4) ? r[15:8] : r[23:16];
        t.last = (o == nps_pkg::OP_JUMP) ? (s == 3'h2) : (s == 3'h5);
        if (s == 3'h0) begin
          t.kind = nps_pkg::K_CMD;
          t.data = (o == nps_pkg::OP_JUMP) ? nps_pkg::CMD_RANDIN : nps_pkg::CMD_LOAD;
        end
      end
      nps_pkg::OP_ERASE: begin
        t.data = (s == 3'h1) ? r[7:0] : (s == 3'h2) ? r[15:8] : r[23:16];
        t.last = (s == 3'h4);
        if (s == 3'h0 || s == 3'h4) begin
          t.kind = nps_pkg::K_CMD;
          t.data = (s == 3'h0) ? nps_pkg::CMD_ERASE_SETUP : nps_pkg::CMD_ERASE_CONF;
        end
      end
      nps_pkg::OP_ID: begin
        t.kind = (s == 3'h0) ? nps_pkg::K_CMD : nps_pkg::K_ADDR;
        t.data = (s == 3'h0) ? nps_pkg::CMD_ID : c[7:0];
        t.last = (s == 3'h1);
      end
      nps_pkg::OP_DATA: t = '{kind: nps_pkg::K_WDATA, last: 1'b1, data: d};
      nps_pkg::OP_CONFIRM: t = '{kind: nps_pkg::K_CMD, last: 1'b1, data: nps_pkg::CMD_CONFIRM};
      nps_pkg::OP_CACHE: t = '{kind: nps_pkg::K_CMD, last: 1'b1, data: nps_pkg::CMD_CACHE};
      nps_pkg::OP_STATUS: t = '{kind: nps_pkg::K_CMD, last: 1'b1, data: nps_pkg::CMD_STATUS};
    endcase
    return t;
  endfunction : seq_byte

  // Status view; device bits are meaningful after the status read that follows ready
  always_comb begin
    stat_rd = '0;
    stat_rd.busy = (state != S_IDLE) && (state != S_LOAD);
    stat_rd.load_phase = (state == S_LOAD);
    stat_rd.err = err;
    stat_rd.rb_ready = rb_s;
    stat_rd.nand_status = nstat;
    stat_rd.chip_pass_fail_bit = nstat[0];
    stat_rd.cache_pass_fail_bit = nstat[1];
    stat_rd.array_ready_bit = nstat[5];
    stat_rd.cache_ready_bit = nstat[6];
    stat_rd.id_count = rcnt;
  end

  assign st = seq_byte(op, step, col, row, dbyte);
  assign same_blk = last_valid && (row[23:nps_pkg::PAGE_BITS] == last_row[23:nps_pkg::PAGE_BITS]);
  assign same_pg = same_blk && (row[nps_pkg::PAGE_BITS-1:0] == last_row[nps_pkg::PAGE_BITS-1:0]);
  assign opc = nps_pkg::nps_op_type'(hwdata[2:0]);
  // A data write waits while the previous byte is still strobing
  assign stall = ap_write && (ap_ofs == nps_pkg::OFS_DATA) && (state == S_ISSUE)
                 && (op == nps_pkg::OP_DATA);

  // Next state of sequencer and bus slave
  always_comb begin
    next_state = state; next_op = op; next_step = step; next_tcnt = tcnt;
    next_pins = pins; next_col = col; next_row = row; next_col_ptr = col_ptr;
    next_dbyte = dbyte; next_nstat = nstat; next_idb = idb; next_rcnt = rcnt;
    next_rlen = rlen; next_err = err; next_last_row = last_row; next_pcnt = pcnt;
    next_last_valid = last_valid; next_ap_valid = ap_valid; next_ap_write = ap_write;
    next_ap_ofs = ap_ofs; next_hreadyout = hreadyout; next_hrdata = hrdata;
    next_tcnt = tcnt + 5'h1;
    unique case (state)
      S_IDLE, S_LOAD: next_tcnt = tcnt;
      S_ISSUE: begin
        // Byte held on IO and CLE/ALE across the strobe rise
        next_pins.ce_n = 1'b0;
        next_pins.cle = (st.kind == nps_pkg::K_CMD);
        next_pins.ale = (st.kind == nps_pkg::K_ADDR);
        next_pins.io_oe = 1'b1;
        next_pins.io_out = st.data;
        next_pins.we_n = (tcnt >= 5'(nps_pkg::WE_LOW_CYC));
        if (tcnt == 5'(nps_pkg::WE_LOW_CYC + nps_pkg::WE_HIGH_CYC - 1)) begin
          next_tcnt = 5'h0;
          next_step = step + 3'h1;
          if (st.last) begin
            next_pins.cle = 1'b0;
            next_pins.ale = 1'b0;
            unique case (op)
              nps_pkg::OP_PROG, nps_pkg::OP_JUMP, nps_pkg::OP_DATA: next_state = S_LOAD;
              nps_pkg::OP_CONFIRM, nps_pkg::OP_CACHE, nps_pkg::OP_ERASE: begin
                next_state = S_WB;
                next_pins.ce_n = 1'b1;
                next_pins.io_oe = 1'b0;
              end
              nps_pkg::OP_ID, nps_pkg::OP_STATUS: begin
                next_state = S_WHR;
                next_pins.io_oe = 1'b0;
                next_rcnt = 3'h0;
                next_rlen = (op == nps_pkg::OP_STATUS) ? nps_pkg::STAT_LEN :
                            (col[7:0] == nps_pkg::ID_ADDR_ONFI) ? nps_pkg::ID_LEN_ONFI :
                            nps_pkg::ID_LEN_STD;
              end
            endcase
          end
        end
      end
      S_WB: if (tcnt == 5'(nps_pkg::WB_CYC - 1)) next_state = S_RDY;
      S_RDY: begin
        next_tcnt = 5'h0;
        // Device ignores other commands while busy, so only status follows ready
        if (rb_s) begin
          next_state = S_ISSUE;
          next_op = nps_pkg::OP_STATUS;
          next_step = 3'h0;
        end
      end
      S_WHR: if (tcnt == 5'(nps_pkg::WHR_CYC - 1)) begin
        next_state = S_READ;
        next_tcnt = 5'h0;
      end
      S_READ: begin
        next_pins.re_n = (tcnt >= 5'(nps_pkg::RE_LOW_CYC));
        if (tcnt == 5'(nps_pkg::RE_LOW_CYC)) begin
          if (op == nps_pkg::OP_STATUS) next_nstat = io_s;
          else next_idb[rcnt] = io_s;
        end
        if (tcnt == 5'(nps_pkg::RE_LOW_CYC + nps_pkg::RE_HIGH_CYC - 1)) begin
          next_tcnt = 5'h0;
          next_rcnt = rcnt + 3'h1;
          if (rcnt + 3'h1 == rlen) begin
            next_state = S_IDLE;
            next_pins.ce_n = 1'b1;
          end
        end
      end
    endcase

    // Bus: one wait state on every transfer, more while a data byte strobes
    if (ap_valid && !stall) begin
      next_ap_valid = 1'b0;
      next_hreadyout = 1'b1;
      next_hrdata = 32'h0000_0000;
      if (!ap_write) begin
        unique case (ap_ofs)
          nps_pkg::OFS_CTRL: next_hrdata = {29'h0, op};
          nps_pkg::OFS_COL: next_hrdata = {16'h0, col};
          nps_pkg::OFS_ROW: next_hrdata = {8'h0, row};
          nps_pkg::OFS_STAT: next_hrdata = stat_rd;
          nps_pkg::OFS_ID_LO: next_hrdata = {idb[3], idb[2], idb[1], idb[0]};
          nps_pkg::OFS_ID_HI: next_hrdata = {24'h0, idb[4]};
          default: next_hrdata = 32'h0000_0000;
        endcase
      end else if (ap_ofs == nps_pkg::OFS_COL) next_col = hwdata[15:0];
      else if (ap_ofs == nps_pkg::OFS_ROW) next_row = hwdata[23:0];
      else if (ap_ofs == nps_pkg::OFS_DATA) begin
        if (state != S_LOAD) next_err[nps_pkg::ERR_REFUSED] = 1'b1;
        else if (col_ptr >= 12'(PAGE_UNITS)) next_err[nps_pkg::ERR_FULL] = 1'b1;
        else begin
          next_dbyte = hwdata[7:0];
          next_op = nps_pkg::OP_DATA;
          next_col_ptr = col_ptr + 12'h1;
          next_state = S_ISSUE;
          next_step = 3'h0;
          next_tcnt = 5'h0;
        end
      end else if (ap_ofs == nps_pkg::OFS_CTRL) begin
        next_err = 4'h0;
        if (state == S_IDLE && opc == nps_pkg::OP_PROG && same_blk &&
            row[nps_pkg::PAGE_BITS-1:0] < last_row[nps_pkg::PAGE_BITS-1:0])
          next_err[nps_pkg::ERR_ORDER] = 1'b1;
        else if (state == S_IDLE && opc == nps_pkg::OP_PROG && same_pg &&
                 pcnt >= 3'(nps_pkg::PARTIAL_MAX))
          next_err[nps_pkg::ERR_PARTIAL] = 1'b1;
        else if ((state == S_IDLE && (opc == nps_pkg::OP_PROG || opc == nps_pkg::OP_ERASE ||
                  opc == nps_pkg::OP_ID || opc == nps_pkg::OP_STATUS)) ||
                 (state == S_LOAD && (opc == nps_pkg::OP_JUMP || opc == nps_pkg::OP_CONFIRM ||
                  opc == nps_pkg::OP_CACHE))) begin
          next_state = S_ISSUE;
          next_op = opc;
          next_step = 3'h0;
          next_tcnt = 5'h0;
          if (opc == nps_pkg::OP_PROG || opc == nps_pkg::OP_JUMP) next_col_ptr = col[11:0];
          if (opc == nps_pkg::OP_PROG) begin
            next_pcnt = same_pg ? pcnt + 3'h1 : 3'h1;
            next_last_row = row;
            next_last_valid = 1'b1;
          end
          if (opc == nps_pkg::OP_ERASE && same_blk) next_last_valid = 1'b0;
        end else next_err[nps_pkg::ERR_REFUSED] = 1'b1;
      end
    end else if (hsel && hready && htrans[1]) begin
      next_ap_valid = 1'b1;
      next_ap_write = hwrite;
      next_ap_ofs = haddr[7:0];
      next_hreadyout = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE; op <= nps_pkg::OP_DATA; step <= 3'h0; tcnt <= 5'h0;
      pins <= nps_pkg::PINS_IDLE; col <= 16'h0; row <= 24'h0; col_ptr <= 12'h0;
      dbyte <= 8'h0; nstat <= 8'h0; rcnt <= 3'h0; rlen <= 3'h0; err <= 4'h0;
      last_row <= 24'h0; pcnt <= 3'h0; last_valid <= 1'b0;
      ap_valid <= 1'b0; ap_write <= 1'b0; ap_ofs <= 8'h0;
      hreadyout <= 1'b1; hrdata <= 32'h0; hresp <= 1'b0;
      for (int i = 0; i < nps_pkg::ID_MAX; i++) idb[i] <= 8'h0;
    end else begin
      state <= next_state; op <= next_op; step <= next_step; tcnt <= next_tcnt;
      pins <= next_pins; col <= next_col; row <= next_row; col_ptr <= next_col_ptr;
      dbyte <= next_dbyte; nstat <= next_nstat; rcnt <= next_rcnt; rlen <= next_rlen;
      err <= next_err; last_row <= next_last_row; pcnt <= next_pcnt;
      last_valid <= next_last_valid; ap_valid <= next_ap_valid; ap_write <= next_ap_write;
      ap_ofs <= next_ap_ofs; hreadyout <= next_hreadyout; hrdata <= next_hrdata;
      hresp <= 1'b0;
      idb <= next_idb;
    end
  end

  // Checker helpers: open program sequence and address cycles since last command
  logic       prog_open;
  logic [2:0] acnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_open <= 1'b0;
      acnt <= 3'h0;
    end else if (pins.we_n && pins.cle && $rose(pins.we_n)) begin
      prog_open <= (pins.io_out == nps_pkg::CMD_LOAD) ||
                   (prog_open && pins.io_out == nps_pkg::CMD_RANDIN);
      acnt <= 3'h0;
    end else if ($rose(pins.we_n) && pins.ale) acnt <= acnt + 3'h1;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence we_pulse_s;
    !pins.we_n [*2] ##1 pins.we_n [*2];
  endsequence
  sequence prog_addr_s;
    state == S_ISSUE && op == nps_pkg::OP_PROG ##1 state == S_LOAD;
  endsequence

  we_pulse_a: assert property ($fell(pins.we_n) |-> we_pulse_s)
    else $error("write strobe shape wrong");
  latch_hold_a: assert property ($rose(pins.we_n) |->
    $stable(pins.io_out) && $stable(pins.cle) && $stable(pins.ale))
    else $error("bus changed at strobe rise");
  cle_ale_excl_a: assert property (!(pins.cle && pins.ale))
    else $error("CLE and ALE both high");
  confirm_open_a: assert property ($rose(pins.we_n) && pins.cle &&
    (pins.io_out == nps_pkg::CMD_CONFIRM || pins.io_out == nps_pkg::CMD_CACHE) |-> prog_open)
    else $error("confirm without load sequence");
  addr_five_a: assert property (prog_addr_s |-> acnt == 3'h5)
    else $error("program address not five cycles");
  ce_free_busy_a: assert property (state == S_WB || state == S_RDY |-> pins.ce_n)
    else $error("chip enable held during busy");
  wait_ready_a: assert property (state == S_RDY && !rb_s |=> state == S_RDY)
    else $error("left busy wait before ready");
  status_after_a: assert property (state == S_RDY && rb_s |=>
    state == S_ISSUE && op == nps_pkg::OP_STATUS ##4 pins.io_out == nps_pkg::CMD_STATUS)
    else $error("no status read after ready");
  page_bound_a: assert property (col_ptr <= 12'(PAGE_UNITS))
    else $error("load beyond page");
  partial_cap_a: assert property (pcnt <= 3'(nps_pkg::PARTIAL_MAX))
    else $error("too many partial programs");
  page_order_a: assert property ($changed(last_row) && $past(last_valid) &&
    last_row[23:nps_pkg::PAGE_BITS] == $past(last_row[23:nps_pkg::PAGE_BITS]) |->
    last_row[5:0] >= $past(last_row[5:0]))
    else $error("page order descending");
  id_len_a: assert property (state == S_READ && op == nps_pkg::OP_ID ##1 state == S_IDLE |->
    rcnt == ((col[7:0] == nps_pkg::ID_ADDR_ONFI) ? 3'h4 : 3'h5))
    else $error("ID byte count wrong");
endmodule : nps_host

// ---- src/nps_pkg.sv ----
// Shared constants and types for the NAND program, erase and ID sequencer.
// Assumes a 25 MHz hclk; all pin timings are derived from it here.
package nps_pkg;
  // Device command codes
  localparam logic [7:0] CMD_LOAD        = 8'h80;
  localparam logic [7:0] CMD_RANDIN      = 8'h85;
  localparam logic [7:0] CMD_CONFIRM     = 8'h10;
  localparam logic [7:0] CMD_CACHE       = 8'h15;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
  localparam logic [7:0] CMD_ID          = 8'h90;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] ID_ADDR_ONFI    = 8'h20;
  localparam logic [2:0] ID_LEN_STD      = 3'h5;
  localparam logic [2:0] ID_LEN_ONFI     = 3'h4;
  localparam logic [2:0] STAT_LEN        = 3'h1;
  localparam int         ID_MAX          = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_COL   = 8'h04;
  localparam logic [7:0] OFS_ROW   = 8'h08;
  localparam logic [7:0] OFS_DATA  = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam logic [7:0] OFS_ID_LO = 8'h14;
  localparam logic [7:0] OFS_ID_HI = 8'h18;

  // Error flag positions in the status register
  localparam int ERR_REFUSED = 0;
  localparam int ERR_ORDER   = 1;
  localparam int ERR_PARTIAL = 2;
  localparam int ERR_FULL    = 3;

  // Geometry
  localparam int PAGE_BITS   = 6;
  localparam int PARTIAL_MAX = 4;

  // Pin timing, least times rounded up to whole cycles
  localparam int CLK_NS       = 40;
  localparam int T_WE_LOW_NS  = 50;
  localparam int T_WE_HIGH_NS = 50;
  localparam int T_RE_LOW_NS  = 200;
  localparam int T_RE_HIGH_NS = 50;
  localparam int T_WB_NS      = 100;
  localparam int T_WHR_NS     = 120;
  localparam int WE_LOW_CYC   = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC  = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RE_LOW_CYC   = (T_RE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RE_HIGH_CYC  = (T_RE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC       = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_CYC      = (T_WHR_NS + CLK_NS - 1) / CLK_NS;

  // Operation codes written to the control register
  typedef enum logic [2:0] {
    OP_DATA    = 3'h0,
    OP_PROG    = 3'h1,
    OP_JUMP    = 3'h2,
    OP_CONFIRM = 3'h3,
    OP_CACHE   = 3'h4,
    OP_ERASE   = 3'h5,
    OP_ID      = 3'h6,
    OP_STATUS  = 3'h7
  } nps_op_type;

  typedef enum logic [1:0] {K_CMD, K_ADDR, K_WDATA} nps_kind_type;

  typedef struct packed {
    nps_kind_type kind;
    logic         last;
    logic [7:0]   data;
  } nps_step_type;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic       io_oe;
    logic [7:0] io_out;
  } nps_pins_type;

  localparam nps_pins_type PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                         re_n: 1'b1, wp_n: 1'b1, io_oe: 1'b0,
                                         io_out: 8'h00};

  typedef struct packed {
    logic [9:0] zero;
    logic [2:0] id_count;
    logic       cache_ready_bit;
    logic       array_ready_bit;
    logic       cache_pass_fail_bit;
    logic       chip_pass_fail_bit;
    logic [7:0] nand_status;
    logic       rb_ready;
    logic [3:0] err;
    logic       load_phase;
    logic       busy;
  } nps_stat_type;
endpackage : nps_pkg

// ---- src/nps_sync.sv ----
// Three-stage input synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to hclk; output moves when stages 2 and 3 agree.
module nps_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Pins in, filtered level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // Stage 1 is read only by stage 2
  always_comb begin
    next_q = (s2 == s3) ? s3 : q;
  end

  // Registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule : nps_sync
